// *** src/pfs_pkg.sv ***
// package: command codes, field positions and carriers for the detailed status bank
package pfs_pkg;
  // ----------------------------------------
  // command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_VOUT = 8'h7A;
  localparam logic [7:0] CMD_IOUT = 8'h7B;
  localparam logic [7:0] CMD_INPUT = 8'h7C;
  localparam logic [7:0] CMD_TEMP = 8'h7D;
  localparam logic [7:0] CMD_CML = 8'h7E;
  // page value that addresses all rails at once
  localparam logic [7:0] PAGE_ALL = 8'hFF;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int VO_OV = 7;
  localparam int VO_UV = 4;
  localparam int VO_MAX = 3;
  localparam int IO_OC = 7;
  localparam int IO_UC = 4;
  localparam int IO_SHARE = 3;
  localparam int IN_OVF = 7;
  localparam int IN_OVW = 6;
  localparam int IN_UVW = 5;
  localparam int IN_UVF = 4;
  localparam int IN_OFF = 3;
  localparam int IN_OCF = 2;
  localparam int IN_OCW = 1;
  localparam int TM_OTF = 7;
  localparam int TM_OTW = 6;
  localparam int TM_UTF = 4;
  localparam int CM_CMD = 7;
  localparam int CM_DATA = 6;
  localparam int CM_PEC = 5;
  localparam int CM_MEM = 4;
  localparam int CM_PROC = 3;
  localparam int CM_OCOMM = 1;
  localparam int CM_OML = 0;
  // supported-bit masks; all other positions read zero
  localparam logic [7:0] MASK_VOUT = 8'h98;
  localparam logic [7:0] MASK_IOUT = 8'h98;
  localparam logic [7:0] MASK_INPUT = 8'hFE;
  localparam logic [7:0] MASK_TEMP = 8'hD0;
  localparam logic [7:0] MASK_CML = 8'hFB;
  localparam logic [7:0] RESET_STATUS = 8'h00;
  localparam logic [7:0] READ_NONE = 8'h00;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic out_ov_fault;
    logic out_uv_fault;
    logic out_max_warn;
    logic out_oc_fault;
    logic out_uc_fault;
    logic share_fault;
    logic in_ov_fault;
    logic in_ov_warn;
    logic in_uv_warn;
    logic in_uv_fault;
    logic in_low_off;
    logic aux_low_off;
    logic in_oc_fault;
    logic in_oc_warn;
    logic ot_fault;
    logic ot_warn;
    logic ut_fault;
  } pfs_rail_ev_t;
  typedef struct packed {
    logic bad_command_flag;
    logic bad_payload_flag;
    logic packet_check_fail_flag;
    logic memory_fault_flag;
    logic processor_fault_flag;
    logic other_comm_fault_flag;
    logic other_memlogic_fault_flag;
  } pfs_cml_ev_t;
  typedef struct packed {
    logic [7:0] vout;
    logic [7:0] iout;
    logic [7:0] input_s;
    logic [7:0] temp;
  } pfs_rail_regs_t;
endpackage

// *** src/pfs_rail_bank.sv ***
// one rail's paged status bytes: sticky bits set by events, cleared by a clear strobe
`timescale 1ns/1ps
module pfs_rail_bank (
  input wire logic ref_clk,
  input wire logic reset,
  input wire pfs_pkg::pfs_rail_ev_t ev,
  input wire logic clear,
  output pfs_pkg::pfs_rail_regs_t regs
);
  pfs_pkg::pfs_rail_regs_t state_q;
  pfs_pkg::pfs_rail_regs_t state_d;
  pfs_pkg::pfs_rail_regs_t set_v;

  always_comb begin
    set_v = '0;
    set_v.vout[pfs_pkg::VO_OV] = ev.out_ov_fault;
    set_v.vout[pfs_pkg::VO_UV] = ev.out_uv_fault;
    set_v.vout[pfs_pkg::VO_MAX] = ev.out_max_warn;
    set_v.iout[pfs_pkg::IO_OC] = ev.out_oc_fault;
    set_v.iout[pfs_pkg::IO_UC] = ev.out_uc_fault;
    set_v.iout[pfs_pkg::IO_SHARE] = ev.share_fault;
    set_v.input_s[pfs_pkg::IN_OVF] = ev.in_ov_fault;
    set_v.input_s[pfs_pkg::IN_OVW] = ev.in_ov_warn;
    set_v.input_s[pfs_pkg::IN_UVW] = ev.in_uv_warn;
    set_v.input_s[pfs_pkg::IN_UVF] = ev.in_uv_fault;
    set_v.input_s[pfs_pkg::IN_OFF] = ev.in_low_off | ev.aux_low_off;
    set_v.input_s[pfs_pkg::IN_OCF] = ev.in_oc_fault;
    set_v.input_s[pfs_pkg::IN_OCW] = ev.in_oc_warn;
    set_v.temp[pfs_pkg::TM_OTF] = ev.ot_fault;
    set_v.temp[pfs_pkg::TM_OTW] = ev.ot_warn;
    set_v.temp[pfs_pkg::TM_UTF] = ev.ut_fault;
    // set wins over a clear in the same cycle
    state_d = clear ? set_v : (state_q | set_v);
    if (reset) begin
      state_d = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    state_q <= state_d;
  end

  assign regs = state_q;
endmodule

// *** src/pfs_status_bank.sv ***
// detailed fault status bank: paged rail bytes, global comm/logic byte, read port
`timescale 1ns/1ps
module pfs_status_bank #(
  parameter int RAILS = 2
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire pfs_pkg::pfs_rail_ev_t [RAILS-1:0] rail_ev,
  input wire pfs_pkg::pfs_cml_ev_t cml_ev,
  input wire logic [7:0] page,
  input wire logic rd_req,
  input wire logic [7:0] rd_cmd,
  input wire logic wr_req,
  input wire logic [7:0] wr_cmd,
  input wire logic [7:0] wr_data,
  input wire logic clear_req,
  output logic rd_valid,
  output logic rd_hit,
  output logic [7:0] rd_data
);
  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (RAILS < 1 || RAILS > 254) begin : g_bad_rails
    $error("RAILS must lie in 1..254");
  end

  typedef struct packed {
    logic [7:0] cml;
    logic valid;
    logic hit;
    logic [7:0] data;
  } pfs_state_t;

  pfs_state_t s_q;
  pfs_state_t s_d;
  pfs_pkg::pfs_rail_regs_t [RAILS-1:0] rail_regs;
  pfs_pkg::pfs_rail_regs_t sel_regs;
  logic [RAILS-1:0] rail_clear;
  logic [7:0] cml_set;
  logic all_pages;
  logic page_ok;

  // ----------------------------------------
  // per-rail sticky banks
  // ----------------------------------------
  for (genvar r = 0; r < RAILS; r++) begin : g_rail
    // clear applies to the selected rail, or to every rail when all are addressed
    assign rail_clear[r] = clear_req & (all_pages | (page == 8'(r)));
    pfs_rail_bank u_bank (
      .ref_clk(ref_clk),
      .reset(reset),
      .ev(rail_ev[r]),
      .clear(rail_clear[r]),
      .regs(rail_regs[r])
    );
  end

  // ----------------------------------------
  // page selection
  // ----------------------------------------
  assign all_pages = (page == pfs_pkg::PAGE_ALL);
  assign page_ok = all_pages | (page < 8'(RAILS));

  always_comb begin
    sel_regs = '0;
    for (int r = 0; r < RAILS; r++) begin
      if (all_pages) begin
        sel_regs = sel_regs | rail_regs[r];
      end else if (page == 8'(r)) begin
        sel_regs = rail_regs[r];
      end
    end
  end

  // ----------------------------------------
  // global comm/logic byte
  // ----------------------------------------
  always_comb begin
    cml_set = '0;
    cml_set[pfs_pkg::CM_CMD] = cml_ev.bad_command_flag;
    cml_set[pfs_pkg::CM_DATA] = cml_ev.bad_payload_flag;
    cml_set[pfs_pkg::CM_PEC] = cml_ev.packet_check_fail_flag;
    cml_set[pfs_pkg::CM_MEM] = cml_ev.memory_fault_flag;
    cml_set[pfs_pkg::CM_PROC] = cml_ev.processor_fault_flag;
    cml_set[pfs_pkg::CM_OCOMM] = cml_ev.other_comm_fault_flag;
    cml_set[pfs_pkg::CM_OML] = cml_ev.other_memlogic_fault_flag;
  end

  function automatic logic [7:0] pick(input logic [7:0] v, input logic [7:0] m);
    pick = v & m;
  endfunction

  // ----------------------------------------
  // read port and state update
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    // writes to these read-only codes are dropped on purpose
    s_d.cml = (clear_req ? 8'h00 : s_q.cml) | cml_set;
    s_d.valid = rd_req;
    s_d.hit = 1'b0;
    s_d.data = pfs_pkg::READ_NONE;
    if (rd_req) begin
      s_d.hit = 1'b1;
      case (rd_cmd)
        pfs_pkg::CMD_VOUT: begin
          s_d.data = pick(sel_regs.vout, pfs_pkg::MASK_VOUT);
        end
        pfs_pkg::CMD_IOUT: begin
          s_d.data = pick(sel_regs.iout, pfs_pkg::MASK_IOUT);
        end
        pfs_pkg::CMD_INPUT: begin
          s_d.data = pick(sel_regs.input_s, pfs_pkg::MASK_INPUT);
        end
        pfs_pkg::CMD_TEMP: begin
          s_d.data = pick(sel_regs.temp, pfs_pkg::MASK_TEMP);
        end
        pfs_pkg::CMD_CML: begin
          s_d.data = pick(s_q.cml, pfs_pkg::MASK_CML);
        end
        default: begin
          s_d.hit = 1'b0;
        end
      endcase
      // a paged code with an out-of-range page answers zero
      if (rd_cmd != pfs_pkg::CMD_CML && !page_ok) begin
        s_d.data = pfs_pkg::READ_NONE;
      end
    end
    if (reset) begin
      s_d = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    s_q <= s_d;
  end

  assign rd_valid = s_q.valid;
  assign rd_hit = s_q.hit;
  assign rd_data = s_q.data;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_rd(logic [7:0] c);
    rd_req && rd_cmd == c && !reset;
  endsequence

  property p_vout_ov;
    @(posedge ref_clk) disable iff (reset)
      rail_ev[0].out_ov_fault ##1 (!clear_req)[*3]
      ##0 (s_rd(pfs_pkg::CMD_VOUT) and page == 8'h00)
      |=> rd_data[pfs_pkg::VO_OV];
  endproperty
  a_vout_ov: assert property (p_vout_ov) else $error("output overvoltage bit missing");

  property p_in_off;
    @(posedge ref_clk) disable iff (reset)
      rail_ev[0].aux_low_off ##1 (!clear_req)[*8]
      ##1 (s_rd(pfs_pkg::CMD_INPUT) and page == 8'h00)
      |=> rd_data[pfs_pkg::IN_OFF];
  endproperty
  a_in_off: assert property (p_in_off) else $error("low input hold-off bit missing");

  property p_vout_mask;
    @(posedge ref_clk) disable iff (reset)
      s_rd(pfs_pkg::CMD_VOUT) |=> (rd_data & ~pfs_pkg::MASK_VOUT) == 8'h00;
  endproperty
  a_vout_mask: assert property (p_vout_mask) else $error("unsupported voltage bits set");

  property p_temp_mask;
    @(posedge ref_clk) disable iff (reset)
      s_rd(pfs_pkg::CMD_TEMP) |=> (rd_data & ~pfs_pkg::MASK_TEMP) == 8'h00;
  endproperty
  a_temp_mask: assert property (p_temp_mask) else $error("unsupported temperature bits set");

  property p_cml_cmd;
    @(posedge ref_clk) disable iff (reset)
      cml_ev.bad_command_flag ##1 (!clear_req)[*3] ##0 s_rd(pfs_pkg::CMD_CML)
      |=> rd_data[pfs_pkg::CM_CMD];
  endproperty
  a_cml_cmd: assert property (p_cml_cmd) else $error("bad command bit missing");

  property p_cml_pec_sticky;
    @(posedge ref_clk) disable iff (reset)
      cml_ev.packet_check_fail_flag ##1 (!clear_req)[*3] ##0 s_rd(pfs_pkg::CMD_CML)
      |=> rd_data[pfs_pkg::CM_PEC];
  endproperty
  a_cml_pec_sticky: assert property (p_cml_pec_sticky) else $error("packet check bit lost");

  property p_cml_global;
    @(posedge ref_clk) disable iff (reset)
      s_rd(pfs_pkg::CMD_CML) |=> rd_data == ($past(s_q.cml) & pfs_pkg::MASK_CML) && rd_hit;
  endproperty
  a_cml_global: assert property (p_cml_global) else $error("global byte depends on page");

  property p_set_wins;
    @(posedge ref_clk) disable iff (reset)
      (cml_ev.memory_fault_flag && clear_req) ##1 (!clear_req)[*3] ##0 s_rd(pfs_pkg::CMD_CML)
      |=> rd_data[pfs_pkg::CM_MEM];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("memory fault lost to clear");

  // reference for the all-rails read, built straight from the rail bytes
  logic [7:0] all_iout;
  always_comb begin
    all_iout = 8'h00;
    for (int r = 0; r < RAILS; r++) begin
      all_iout = all_iout | (rail_regs[r].iout & pfs_pkg::MASK_IOUT);
    end
  end

  property p_all_or;
    @(posedge ref_clk) disable iff (reset)
      (all_pages and s_rd(pfs_pkg::CMD_IOUT))
      |=> rd_data == $past(all_iout);
  endproperty
  a_all_or: assert property (p_all_or) else $error("paged read mismatch");

  property p_write_ignored;
    @(posedge ref_clk) disable iff (reset)
      (wr_req && !clear_req && cml_set == 8'h00) |=> s_q.cml == $past(s_q.cml);
  endproperty
  a_write_ignored: assert property (p_write_ignored) else $error("write changed status");

  // ----------------------------------------
  // latching and read answer
  // ----------------------------------------
  property p_vout_uv;
    @(posedge ref_clk) disable iff (reset)
      rail_ev[0].out_uv_fault |=> rail_regs[0].vout[pfs_pkg::VO_UV];
  endproperty
  a_vout_uv: assert property (p_vout_uv) else $error("undervoltage bit not latched");

  property p_vout_max;
    @(posedge ref_clk) disable iff (reset)
      rail_ev[0].out_max_warn |=> rail_regs[0].vout[pfs_pkg::VO_MAX];
  endproperty
  a_vout_max: assert property (p_vout_max) else $error("voltage max bit not latched");

  property p_iout_oc;
    @(posedge ref_clk) disable iff (reset)
      rail_ev[0].out_oc_fault |=> rail_regs[0].iout[pfs_pkg::IO_OC];
  endproperty
  a_iout_oc: assert property (p_iout_oc) else $error("overcurrent bit not latched");

  property p_iout_uc;
    @(posedge ref_clk) disable iff (reset)
      rail_ev[0].out_uc_fault |=> rail_regs[0].iout[pfs_pkg::IO_UC];
  endproperty
  a_iout_uc: assert property (p_iout_uc) else $error("undercurrent bit not latched");

  property p_iout_share;
    @(posedge ref_clk) disable iff (reset)
      rail_ev[0].share_fault |=> rail_regs[0].iout[pfs_pkg::IO_SHARE];
  endproperty
  a_iout_share: assert property (p_iout_share) else $error("share bit not latched");

  property p_in_ovw;
    @(posedge ref_clk) disable iff (reset)
      rail_ev[0].in_ov_warn |=> rail_regs[0].input_s[pfs_pkg::IN_OVW];
  endproperty
  a_in_ovw: assert property (p_in_ovw) else $error("input ov warning not latched");

  property p_in_uv;
    @(posedge ref_clk) disable iff (reset)
      rail_ev[0].in_uv_fault |=> rail_regs[0].input_s[pfs_pkg::IN_UVF];
  endproperty
  a_in_uv: assert property (p_in_uv) else $error("input uv fault not latched");

  property p_in_oc;
    @(posedge ref_clk) disable iff (reset)
      rail_ev[0].in_oc_fault |=> rail_regs[0].input_s[pfs_pkg::IN_OCF];
  endproperty
  a_in_oc: assert property (p_in_oc) else $error("input oc fault not latched");

  property p_temp_ot;
    @(posedge ref_clk) disable iff (reset)
      rail_ev[0].ot_fault |=> rail_regs[0].temp[pfs_pkg::TM_OTF];
  endproperty
  a_temp_ot: assert property (p_temp_ot) else $error("over-temperature not latched");

  property p_cml_data;
    @(posedge ref_clk) disable iff (reset)
      cml_ev.bad_payload_flag |=> s_q.cml[pfs_pkg::CM_DATA];
  endproperty
  a_cml_data: assert property (p_cml_data) else $error("bad payload bit not latched");

  property p_cml_proc;
    @(posedge ref_clk) disable iff (reset)
      cml_ev.processor_fault_flag |=> s_q.cml[pfs_pkg::CM_PROC];
  endproperty
  a_cml_proc: assert property (p_cml_proc) else $error("processor bit not latched");

  property p_cml_other;
    @(posedge ref_clk) disable iff (reset)
      cml_ev.other_comm_fault_flag |=> s_q.cml[pfs_pkg::CM_OCOMM];
  endproperty
  a_cml_other: assert property (p_cml_other) else $error("other comm bit not latched");

  property p_rd_answer;
    @(posedge ref_clk) disable iff (reset)
      rd_req |=> rd_valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");

  property p_rd_stands;
    @(posedge ref_clk) disable iff (reset)
      !rd_req |=> !rd_valid && !rd_hit && rd_data == 8'h00;
  endproperty
  a_rd_stands: assert property (p_rd_stands) else $error("answer outlived its read");

  property p_unknown;
    @(posedge ref_clk) disable iff (reset)
      (rd_req && (rd_cmd < pfs_pkg::CMD_VOUT || rd_cmd > pfs_pkg::CMD_CML))
      |=> !rd_hit && rd_data == 8'h00;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown code answered");

  property p_page_out;
    @(posedge ref_clk) disable iff (reset)
      (rd_req && rd_cmd != pfs_pkg::CMD_CML && page != pfs_pkg::PAGE_ALL && page >= 8'(RAILS))
      |=> rd_data == 8'h00;
  endproperty
  a_page_out: assert property (p_page_out) else $error("absent page returned data");
endmodule

// *** sim/pfs_host_model.sv ***
// host side model: issues single-byte status reads and captures the answer
`timescale 1ns/1ps
module pfs_host_model (
  input wire logic ref_clk,
  output logic rd_req,
  output logic [7:0] rd_cmd,
  input wire logic rd_valid,
  input wire logic rd_hit,
  input wire logic [7:0] rd_data,
  output logic got_hit,
  output logic [7:0] got_data,
  output logic lost
);
  initial begin
    rd_req = 1'b0;
    rd_cmd = 8'h00;
    got_hit = 1'b0;
    got_data = 8'h00;
    lost = 1'b0;
  end
  // ----------------------------------------
  // one read; request stands for one edge
  // ----------------------------------------
  task automatic read(input logic [7:0] cmd);
    int n;
    @(negedge ref_clk);
    rd_req = 1'b1;
    rd_cmd = cmd;
    @(negedge ref_clk);
    rd_req = 1'b0;
    // released code lines carry the inverse so a stale value never matches
    rd_cmd = ~cmd;
    lost = 1'b1;
    for (n = 0; n < 4; n++) begin
      if (rd_valid === 1'b1) begin
        got_hit = rd_hit;
        got_data = rd_data;
        lost = 1'b0;
        break;
      end
      @(negedge ref_clk);
    end
  endtask
endmodule

// *** sim/test_pfs_status_bank.sv ***
// testbench for the detailed fault status bank
`timescale 1ns/1ps
module test_pfs_status_bank;
  localparam int RAILS = 2;
  localparam logic [7:0] CODES [17] = '{8'h7A, 8'h7A, 8'h7A, 8'h7B, 8'h7B, 8'h7B,
    8'h7C, 8'h7C, 8'h7C, 8'h7C, 8'h7C, 8'h7C, 8'h7C, 8'h7C, 8'h7D, 8'h7D, 8'h7D};
  localparam int BITS [17] = '{7, 4, 3, 7, 4, 3, 7, 6, 5, 4, 3, 3, 2, 1, 7, 6, 4};
  localparam int CBITS [7] = '{7, 6, 5, 4, 3, 1, 0};
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  pfs_pkg::pfs_rail_ev_t [RAILS-1:0] rail_ev = '0;
  pfs_pkg::pfs_cml_ev_t cml_ev = '0;
  logic [7:0] page = 8'h00;
  logic wr_req = 1'b0;
  logic [7:0] wr_cmd = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic clear_req = 1'b0;
  logic rd_req, rd_valid, rd_hit, got_hit, lost;
  logic [7:0] rd_cmd, rd_data, got_data;
  int error_cnt = 0;
  int checks = 0;
  pfs_status_bank #(.RAILS(RAILS)) u_dut (.ref_clk(ref_clk), .reset(reset),
    .rail_ev(rail_ev), .cml_ev(cml_ev), .page(page), .rd_req(rd_req), .rd_cmd(rd_cmd),
    .wr_req(wr_req), .wr_cmd(wr_cmd), .wr_data(wr_data), .clear_req(clear_req),
    .rd_valid(rd_valid), .rd_hit(rd_hit), .rd_data(rd_data));
  pfs_host_model u_host (.ref_clk(ref_clk), .rd_req(rd_req), .rd_cmd(rd_cmd),
    .rd_valid(rd_valid), .rd_hit(rd_hit), .rd_data(rd_data), .got_hit(got_hit),
    .got_data(got_data), .lost(lost));
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] cmd, input logic h,
                    input logic [7:0] d);
    @(negedge ref_clk);
    page = p;
    u_host.read(cmd);
    if (lost !== 1'b0) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, lost, 1'b0);
      finish_test();
    end
    chk({7'h00, got_hit}, {7'h00, h});
    chk(got_data, d);
  endtask
  task automatic pulse(input int r, input pfs_pkg::pfs_rail_ev_t v);
    @(negedge ref_clk);
    rail_ev[r] = v;
    @(negedge ref_clk);
    rail_ev[r] = '0;
  endtask
  task automatic clr(input logic [7:0] p);
    @(negedge ref_clk);
    page = p;
    clear_req = 1'b1;
    @(negedge ref_clk);
    clear_req = 1'b0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_codes();
    rd(8'h00, 8'h7A, 1'b1, 8'h00);
    rd(8'h00, 8'h7B, 1'b1, 8'h00);
    rd(8'h00, 8'h7C, 1'b1, 8'h00);
    rd(8'h00, 8'h7D, 1'b1, 8'h00);
    rd(8'h00, 8'h7E, 1'b1, 8'h00);
    rd(8'h00, 8'h79, 1'b0, 8'h00);
    rd(8'h00, 8'h7F, 1'b0, 8'h00);
  endtask
  task automatic t_rail_bits();
    logic [7:0] c;
    for (int i = 0; i < 17; i++) begin
      pulse(0, pfs_pkg::pfs_rail_ev_t'(17'h00001 << (16 - i)));
      for (int k = 0; k < 4; k++) begin
        c = 8'h7A + 8'(k);
        // every other paged byte must stay zero, unsupported bits included
        rd(8'h00, c, 1'b1, (c == CODES[i]) ? 8'(8'h01 << BITS[i]) : 8'h00);
      end
      clr(8'h00);
    end
  endtask
  task automatic t_paging();
    pulse(1, pfs_pkg::pfs_rail_ev_t'(17'h02004));
    pulse(0, pfs_pkg::pfs_rail_ev_t'(17'h00001));
    rd(8'h00, 8'h7D, 1'b1, 8'h10);
    rd(8'h01, 8'h7D, 1'b1, 8'h80);
    rd(8'hFF, 8'h7D, 1'b1, 8'h90);
    rd(8'hFF, 8'h7B, 1'b1, 8'h80);
    rd(8'h02, 8'h7D, 1'b1, 8'h00);
    clr(8'h01);
    rd(8'hFF, 8'h7D, 1'b1, 8'h10);
    clr(8'hFF);
    rd(8'hFF, 8'h7D, 1'b1, 8'h00);
  endtask
  task automatic t_cml_bits();
    for (int j = 0; j < 7; j++) begin
      @(negedge ref_clk);
      cml_ev = pfs_pkg::pfs_cml_ev_t'(7'h01 << (6 - j));
      @(negedge ref_clk);
      cml_ev = '0;
      rd(8'(j % 2), 8'h7E, 1'b1, 8'(8'h01 << CBITS[j]));
      clr(8'h00);
    end
    // a fault in the same cycle as a clear must survive it
    @(negedge ref_clk);
    cml_ev.memory_fault_flag = 1'b1;
    clear_req = 1'b1;
    @(negedge ref_clk);
    cml_ev = '0;
    clear_req = 1'b0;
    rd(8'h00, 8'h7E, 1'b1, 8'h10);
    clr(8'h00);
  endtask
  task automatic t_writes();
    pulse(0, pfs_pkg::pfs_rail_ev_t'(17'h10000));
    @(negedge ref_clk);
    wr_req = 1'b1;
    wr_cmd = 8'h7A;
    @(negedge ref_clk);
    wr_cmd = 8'h7E;
    wr_data = 8'hFF;
    @(negedge ref_clk);
    wr_req = 1'b0;
    rd(8'h00, 8'h7A, 1'b1, 8'h80);
    rd(8'h00, 8'h7E, 1'b1, 8'h00);
  endtask
  initial begin
    repeat (4) @(negedge ref_clk);
    reset = 1'b0;
    t_reset_codes();
    t_rail_bits();
    t_paging();
    t_cml_bits();
    t_writes();
    finish_test();
  end
endmodule
